// ===== adcc_clkgen.sv
module adcc_clkgen
  import adcc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       rc_osc_in,
  input  wire logic       sel_rc,
  input  wire logic [5:0] div,
  output logic            tick
);

  // ----------------------------------------------------------------
  // RC oscillator edge, brought in through three flops
  // ----------------------------------------------------------------
  logic       rc_s1;
  logic       rc_s2;
  logic       rc_s3;
  logic [6:0] cnt;
  logic [6:0] limit;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end else begin
      rc_s1 <= rc_osc_in;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end

  // ----------------------------------------------------------------
  // Divided system clock: one tick every 2*(div+1) cycles
  // ----------------------------------------------------------------
  assign limit = {div, 1'b1};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 7'h00;
    end else if (cnt >= limit) begin
      cnt <= 7'h00;
    end else begin
      cnt <= cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else if (sel_rc) begin
      tick <= rc_s2 & ~rc_s3;
    end else begin
      tick <= (cnt >= limit);
    end
  end

endmodule

// ===== adcc_monitor.sv
module adcc_monitor
  import adcc_pkg::*;
#(
  parameter int ACQ_TICKS = ACQ_TICKS_DEF
)(
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rc_osc_in,
  input wire logic              conv_done_in,
  input wire logic [RAW_W-1:0]  conv_data_in,
  input wire logic              threshold_irq_flag,
  input wire logic              conv_clk_tick,
  input wire logic              conv_req,
  input wire logic              precharge_on,
  input wire logic              precharge_high,
  input wire logic              guard_high,
  input wire logic              irq
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Completion is only trusted once the done line has been low long enough to clear the synchroniser.
  sequence s_done_quiet;
    !conv_done_in [*4];
  endsequence
  sequence s_done_edge;
    conv_req && $rose(conv_done_in);
  endsequence

  a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("read data outside a read");
  a_stage_excl: assert property (!(precharge_on && conv_req)) else $error("precharge during conversion");
  a_acq_first: assert property ($rose(conv_req) |-> !$past(precharge_on)) else $error("no acquisition gap");
  a_done_ends_req: assert property (s_done_edge |-> ##[1:6] !conv_req) else $error("conversion not ended");
  a_req_holds: assert property (s_done_quiet ##0 (conv_req && !wr) |=> conv_req) else $error("conversion dropped");
  a_tick_pulse: assert property (conv_clk_tick |=> !conv_clk_tick) else $error("tick longer than a cycle");
  a_pre_pol_stable: assert property (precharge_on && $past(precharge_on) |-> $stable(precharge_high))
    else $error("precharge level moved");
  a_guard_stable: assert property (precharge_on && $past(precharge_on) |-> $stable(guard_high))
    else $error("guard level moved");
endmodule

bind adcc_top adcc_monitor #(.ACQ_TICKS(ACQ_TICKS)) i_mon (
  .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .rc_osc_in(rc_osc_in), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
  .threshold_irq_flag(threshold_irq_flag), .conv_clk_tick(conv_clk_tick), .conv_req(conv_req),
  .precharge_on(precharge_on), .precharge_high(precharge_high), .guard_high(guard_high), .irq(irq)
);

// ===== adcc_pkg.sv
// Function
// - Continuous run re-asserts go after completion
// - Single run clears go after conversion unless burst mode has samples left
// - Clock source selects RC or divided clock
// - Justify bit selects right or left format
// - Go held high while cycle runs
// - Precharge shorts to supply or ground
// - Inverted precharge flips second pair conversion
// - Guard polarity sets guard starting level
// - Double sample computes every second conversion
// - Start copies filter or result to previous
// - Low-pass filter with 2^shift time constant
// - Accumulating modes right-shift by shift field
// - Basic mode ignores shift; codes reserved
// - Accumulator clear command, self-clearing
// - Mode field decode, upper codes reserved
// - Stop-on-threshold ends continuous retriggering
package adcc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 8;
  localparam logic [11:0] OFF_CLKDIV   = 12'hf57;
  localparam logic [11:0] OFF_CTRL1    = 12'hf59;
  localparam logic [11:0] OFF_CTRL2    = 12'hf5a;
  localparam logic [11:0] OFF_CTRL3    = 12'hf5b;
  localparam logic [11:0] OFF_PRE      = 12'hf5e;
  localparam logic [11:0] OFF_CTRL0    = 12'hf60;
  localparam logic [11:0] OFF_PREV_L   = 12'hf61;
  localparam logic [11:0] OFF_PREV_H   = 12'hf62;
  localparam logic [11:0] OFF_RES_L    = 12'hf63;
  localparam logic [11:0] OFF_RES_H    = 12'hf64;
  localparam logic [11:0] OFF_STAT     = 12'hf65;
  localparam logic [11:0] OFF_RPT      = 12'hf66;
  localparam logic [11:0] OFF_CNT      = 12'hf67;
  localparam logic [11:0] OFF_ACC_L    = 12'hf70;
  localparam logic [11:0] OFF_ACC_H    = 12'hf71;
  localparam logic [11:0] OFF_FLT_L    = 12'hf72;
  localparam logic [11:0] OFF_FLT_H    = 12'hf73;
  localparam logic [11:0] OFF_IRQ_STAT = 12'hf80;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'hf81;
  localparam logic [11:0] OFF_IRQ_EN   = 12'hf82;
  localparam logic [7:0]  REG_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C0_ON     = 7;
  localparam int C0_CONT   = 6;
  localparam int C0_CS     = 4;
  localparam int C0_FM     = 2;
  localparam int C0_GO     = 0;
  localparam int C1_PPOL   = 7;
  localparam int C1_IPEN   = 6;
  localparam int C1_GPOL   = 5;
  localparam int C1_DSEN   = 0;
  localparam int C2_PSIS   = 7;
  localparam int C2_CRS_LO = 4;
  localparam int C2_ACLR   = 3;
  localparam int C2_MD_LO  = 0;
  localparam int C3_SOI    = 3;
  localparam int ST_AOV    = 7;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_CALC  = 1;
  localparam int IRQ_OVF   = 2;

  // ----------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] MD_BASIC = 3'h0;
  localparam logic [2:0] MD_ACCUM = 3'h1;
  localparam logic [2:0] MD_AVG   = 3'h2;
  localparam logic [2:0] MD_BURST = 3'h3;
  localparam logic [2:0] MD_LPF   = 3'h4;
  localparam logic [1:0] STG_IDLE = 2'h0;
  localparam logic [1:0] STG_PRE  = 2'h1;
  localparam logic [1:0] STG_ACQ  = 2'h2;
  localparam logic [1:0] STG_CONV = 2'h3;
  localparam int         ACQ_TICKS_DEF = 2;
  localparam int         RAW_W         = 10;

  typedef enum logic [1:0] {S_IDLE, S_PRE, S_ACQ, S_CONV} adcc_state_t;

endpackage

// ===== adcc_top.sv
module adcc_top
  import adcc_pkg::*;
#(
  parameter int ACQ_TICKS = ACQ_TICKS_DEF
)(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [DATA_W-1:0]      rdata,
  input  wire logic              rc_osc_in,
  input  wire logic              conv_done_in,
  input  wire logic [RAW_W-1:0]  conv_data_in,
  input  wire logic              threshold_irq_flag,
  output logic                   conv_clk_tick,
  output logic                   conv_req,
  output logic                   precharge_on,
  output logic                   precharge_high,
  output logic                   guard_high,
  output logic                   irq
);

  generate
    if (ACQ_TICKS < 1 || ACQ_TICKS > 255) begin : g_bad_acq
      $error("ACQ_TICKS must lie in 1..255");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic             rst_s1;
  logic             rst_n;
  logic             done_s1;
  logic             done_s2;
  logic             done_s3;
  logic [RAW_W-1:0] data_s1;
  logic [RAW_W-1:0] data_s2;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      done_s1 <= conv_done_in;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      data_s1 <= conv_data_in;
      data_s2 <= data_s1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl0;
  logic [7:0]  ctrl1;
  logic [7:0]  ctrl2;
  logic [7:0]  ctrl3;
  logic [7:0]  pre_time;
  logic [5:0]  clk_div;
  logic [7:0]  repeat_target;
  logic [7:0]  sample_counter;
  logic [15:0] accumulator;
  logic [15:0] filter_output;
  logic [15:0] conversion_result;
  logic [15:0] previous_result;
  logic        accumulator_overflow;
  logic        conversion_go;
  logic        accumulator_clear_cmd;
  logic [2:0]  irq_status;
  logic [2:0]  irq_enable;
  logic [2:0]  events;
  logic        second;

  wire       converter_on          = ctrl0[C0_ON];
  wire       continuous_run        = ctrl0[C0_CONT];
  wire       conv_clock_source     = ctrl0[C0_CS];
  wire       result_justify        = ctrl0[C0_FM];
  wire       precharge_polarity    = ctrl1[C1_PPOL];
  wire       inverted_precharge_en = ctrl1[C1_IPEN];
  wire       guard_polarity        = ctrl1[C1_GPOL];
  wire       double_sample_en      = ctrl1[C1_DSEN];
  wire       previous_source_sel   = ctrl2[C2_PSIS];
  wire [2:0] calc_right_shift      = ctrl2[C2_CRS_LO +: 3];
  wire [2:0] operating_mode_sel    = ctrl2[C2_MD_LO +: 3];
  wire       stop_on_threshold     = ctrl3[C3_SOI];

  wire wr_ctrl0 = wr && (addr == OFF_CTRL0);
  wire wr_ctrl2 = wr && (addr == OFF_CTRL2);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0         <= REG_RESET;
      ctrl1         <= REG_RESET;
      ctrl2         <= REG_RESET;
      ctrl3         <= REG_RESET;
      pre_time      <= REG_RESET;
      clk_div       <= 6'h00;
      repeat_target <= REG_RESET;
      irq_enable    <= 3'h0;
    end else if (wr) begin
      unique case (addr)
        OFF_CTRL0:  ctrl0         <= wdata;
        OFF_CTRL1:  ctrl1         <= wdata;
        OFF_CTRL2:  ctrl2         <= wdata;
        OFF_CTRL3:  ctrl3         <= wdata;
        OFF_PRE:    pre_time      <= wdata;
        OFF_CLKDIV: clk_div       <= wdata[5:0];
        OFF_RPT:    repeat_target <= wdata;
        OFF_IRQ_EN: irq_enable    <= wdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  adcc_clkgen u_clkgen (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .rc_osc_in (rc_osc_in),
    .sel_rc    (conv_clock_source),
    .div       (clk_div),
    .tick      (conv_clk_tick)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  adcc_state_t state;
  adcc_state_t next_state;
  logic [7:0]  stage_cnt;
  logic        complete;
  logic        computes;
  logic        burst_more;
  logic        retrigger;
  logic        aclr_fire;

  assign complete   = (state == S_CONV) && done_s2 && !done_s3;
  assign computes   = complete && (!double_sample_en || second);
  assign burst_more = (operating_mode_sel == MD_BURST) && (sample_counter + 8'h01 < repeat_target);
  assign retrigger  = (continuous_run && !(stop_on_threshold && threshold_irq_flag)) || burst_more;
  assign aclr_fire  = accumulator_clear_cmd && conv_clk_tick;

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (conversion_go && converter_on && !accumulator_clear_cmd) next_state = S_PRE;
      S_PRE:  if (pre_time == 8'h00 || (conv_clk_tick && stage_cnt + 8'h01 >= pre_time)) next_state = S_ACQ;
      S_ACQ:  if (conv_clk_tick && stage_cnt + 8'h01 >= 8'(ACQ_TICKS)) next_state = S_CONV;
      S_CONV: if (complete) next_state = S_IDLE;
    endcase
    if (!converter_on) next_state = S_IDLE;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= S_IDLE;
      stage_cnt <= 8'h00;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        stage_cnt <= 8'h00;
      end else if (conv_clk_tick) begin
        stage_cnt <= stage_cnt + 8'h01;
      end
    end
  end

  // Go bit: a software set wins over a completion clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_go <= 1'b0;
    end else if (wr_ctrl0) begin
      conversion_go <= wdata[C0_GO] & wdata[C0_ON];
    end else if (!converter_on) begin
      conversion_go <= 1'b0;
    end else if (complete && !retrigger) begin
      conversion_go <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      second <= 1'b0;
    end else if (!double_sample_en || !converter_on) begin
      second <= 1'b0;
    end else if (complete) begin
      second <= ~second;
    end
  end

  // Precharge enable and conversion request are registered from the next state so they move with it.
  wire inv_pol = double_sample_en && inverted_precharge_en && second;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      precharge_on   <= 1'b0;
      precharge_high <= 1'b0;
      guard_high     <= 1'b0;
      conv_req       <= 1'b0;
    end else begin
      precharge_on   <= (next_state == S_PRE) && (pre_time != 8'h00);
      precharge_high <= precharge_polarity ^ inv_pol;
      guard_high     <= guard_polarity ^ inv_pol;
      conv_req       <= (next_state == S_CONV);
    end
  end

  // ----------------------------------------------------------------
  // Results and computation
  // ----------------------------------------------------------------
  wire [15:0] raw16    = {6'h00, data_s2};
  wire [16:0] acc_sum  = {1'b0, accumulator} + {1'b0, raw16};
  wire [16:0] lpf_sum  = {1'b0, accumulator} - {1'b0, accumulator >> calc_right_shift} + {1'b0, raw16};
  wire        avg_full = (sample_counter + 8'h01 >= repeat_target);
  wire [7:0]  cnt_inc  = (sample_counter == 8'hff) ? 8'hff : sample_counter + 8'h01;
  logic       ovf_now;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_result <= 16'h0000;
      previous_result   <= 16'h0000;
    end else begin
      if (state == S_IDLE && next_state == S_PRE) begin
        previous_result <= previous_source_sel ? filter_output : conversion_result;
      end
      if (complete) begin
        conversion_result <= result_justify ? raw16 : {data_s2, 6'h00};
      end
    end
  end

  always_comb begin
    ovf_now = 1'b0;
    if (computes) begin
      unique case (operating_mode_sel)
        MD_ACCUM, MD_AVG, MD_BURST: ovf_now = acc_sum[16];
        MD_LPF:                     ovf_now = lpf_sum[16];
        default:                    ovf_now = 1'b0;
      endcase
    end
  end

  // Reserved modes leave the accumulator, counter, filter and overflow flag alone, as basic mode does; shift codes 0 and 7 are
  // used as written because the filter and shifter have no special case.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator          <= 16'h0000;
      accumulator_overflow <= 1'b0;
      sample_counter       <= 8'h00;
      filter_output        <= 16'h0000;
    end else if (aclr_fire) begin
      accumulator          <= 16'h0000;
      accumulator_overflow <= 1'b0;
      sample_counter       <= 8'h00;
    end else if (computes) begin
      accumulator_overflow <= accumulator_overflow | ovf_now;
      unique case (operating_mode_sel)
        MD_ACCUM: begin
          accumulator    <= acc_sum[15:0];
          sample_counter <= cnt_inc;
          filter_output  <= acc_sum[15:0] >> calc_right_shift;
        end
        MD_AVG, MD_BURST: begin
          if (avg_full) begin
            filter_output  <= acc_sum[15:0] >> calc_right_shift;
            accumulator    <= 16'h0000;
            sample_counter <= 8'h00;
          end else begin
            accumulator    <= acc_sum[15:0];
            sample_counter <= cnt_inc;
          end
        end
        MD_LPF: begin
          accumulator    <= lpf_sum[15:0];
          filter_output  <= lpf_sum[15:0] >> calc_right_shift;
          sample_counter <= cnt_inc;
        end
        default: ;
      endcase
    end
  end

  // Clear command: waits for a conversion-clock tick, so it may take long
  // when the slow source is selected. A new write of one wins over the clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator_clear_cmd <= 1'b0;
    end else if (wr_ctrl2 && wdata[C2_ACLR]) begin
      accumulator_clear_cmd <= 1'b1;
    end else if (aclr_fire) begin
      accumulator_clear_cmd <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign events = {ovf_now && !accumulator_overflow,
                   computes && (operating_mode_sel != MD_BASIC),
                   complete};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 3'h0;
    end else if (wr && addr == OFF_IRQ_CLR) begin
      irq_status <= (irq_status & ~wdata[2:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [1:0] stage_code;
  logic [7:0] rd_mux;

  always_comb begin
    unique case (state)
      S_PRE:   stage_code = STG_PRE;
      S_ACQ:   stage_code = STG_ACQ;
      S_CONV:  stage_code = STG_CONV;
      default: stage_code = STG_IDLE;
    endcase
  end

  always_comb begin
    unique case (addr)
      OFF_CTRL0:    rd_mux = {ctrl0[7:1], conversion_go} & 8'hd5;
      OFF_CTRL1:    rd_mux = ctrl1 & 8'he1;
      OFF_CTRL2:    rd_mux = {ctrl2[7:4], accumulator_clear_cmd, ctrl2[2:0]};
      OFF_CTRL3:    rd_mux = ctrl3 & 8'h7f;
      OFF_PRE:      rd_mux = pre_time;
      OFF_CLKDIV:   rd_mux = {2'h0, clk_div};
      OFF_RPT:      rd_mux = repeat_target;
      OFF_CNT:      rd_mux = sample_counter;
      OFF_PREV_L:   rd_mux = previous_result[7:0];
      OFF_PREV_H:   rd_mux = previous_result[15:8];
      OFF_RES_L:    rd_mux = conversion_result[7:0];
      OFF_RES_H:    rd_mux = conversion_result[15:8];
      OFF_ACC_L:    rd_mux = accumulator[7:0];
      OFF_ACC_H:    rd_mux = accumulator[15:8];
      OFF_FLT_L:    rd_mux = filter_output[7:0];
      OFF_FLT_H:    rd_mux = filter_output[15:8];
      OFF_STAT:     rd_mux = {accumulator_overflow, 4'h0, second, stage_code};
      OFF_IRQ_STAT: rd_mux = {5'h00, irq_status};
      OFF_IRQ_EN:   rd_mux = {5'h00, irq_enable};
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// ===== adcc_top_bench.sv
module adcc_top_bench
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] addr = 12'h000;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              rc_osc_in = 1'b0;
  logic              rc_run = 1'b0;
  logic [2:0]        rc_cnt = 3'h0;
  logic              conv_done_in = 1'b0;
  logic [RAW_W-1:0]  conv_data_in = 10'h000;
  logic              threshold_irq_flag = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              conv_clk_tick;
  logic              conv_req;
  logic              precharge_on;
  logic              precharge_high;
  logic              guard_high;
  logic              irq;
  logic [7:0]        v;
  int                n_fail = 0;
  int                total_checks = 0;

  // A short acquisition keeps each conversion to a few dozen cycles.
  adcc_top #(.ACQ_TICKS(1)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rc_osc_in(rc_osc_in), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
    .threshold_irq_flag(threshold_irq_flag), .conv_clk_tick(conv_clk_tick), .conv_req(conv_req),
    .precharge_on(precharge_on), .precharge_high(precharge_high), .guard_high(guard_high), .irq(irq)
  );

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    rc_cnt    <= rc_cnt + 3'h1;
    rc_osc_in <= rc_run & rc_cnt[2];
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(nm, d, exp);
  endtask

  task automatic wait_for(input int s, input logic lvl);
    int n;
    n = 0;
    while ((s == 0 ? conv_req : precharge_on) !== lvl && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 2000) chk("wait", 8'h00, 8'h01);
  endtask

  task automatic conv(input logic [9:0] d);
    wait_for(0, 1'b1);
    @(posedge ref_clk);
    conv_data_in <= d;
    @(posedge ref_clk);
    conv_done_in <= 1'b1;
    wait_for(0, 1'b0);
    @(posedge ref_clk);
    conv_done_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic cnt_ticks(input int exp);
    int n;
    n = 0;
    repeat (8) @(negedge ref_clk);
    repeat (80) begin
      @(negedge ref_clk);
      if (conv_clk_tick === 1'b1) n++;
    end
    chk("ticks", 8'((n >= exp - 1) && (n <= exp + 1)), 8'h01);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_chk("ctrl0", OFF_CTRL0, REG_RESET);
    rd_chk("ctrl1", OFF_CTRL1, REG_RESET);
    rd_chk("ctrl2", OFF_CTRL2, REG_RESET);
    wr_reg(OFF_CTRL1, 8'he1);
    rd_chk("ctrl1", OFF_CTRL1, 8'he1);
    rd_chk("unmapped", 12'h000, 8'h00);
    for (int m = 0; m < 5; m++) begin
      wr_reg(OFF_CTRL2, {5'h02, m[2:0]});
      rd_chk("mode", OFF_CTRL2, {5'h02, m[2:0]});
    end
    wr_reg(OFF_CTRL0, 8'h01);
    rd_chk("go_off", OFF_CTRL0, 8'h00);
    repeat (20) @(negedge ref_clk);
    chk("req_off", {7'h00, conv_req}, 8'h00);
    $display("test registers done");
    wr_reg(OFF_CLKDIV, 8'h01);
    wr_reg(OFF_CTRL0, 8'h80);
    cnt_ticks(20);
    rc_run <= 1'b1;
    wr_reg(OFF_CTRL0, 8'h90);
    cnt_ticks(10);
    rc_run <= 1'b0;
    wr_reg(OFF_CTRL0, 8'h80);
    wr_reg(OFF_CLKDIV, 8'h00);
    $display("test clock done");
    wr_reg(OFF_PRE, 8'h08);
    for (int i = 0; i < 2; i++) begin
      wr_reg(OFF_CTRL1, i ? 8'ha0 : 8'h00);
      wr_reg(OFF_CTRL0, i ? 8'h85 : 8'h81);
      rd_chk("go_busy", OFF_CTRL0, i ? 8'h85 : 8'h81);
      wait_for(1, 1'b1);
      chk("pre_pol", {7'h00, precharge_high}, 8'(i));
      chk("guard", {7'h00, guard_high}, 8'(i));
      conv(10'h2a5);
      rd_chk("go_clr", OFF_CTRL0, i ? 8'h84 : 8'h80);
      rd_chk("res_h", OFF_RES_H, i ? 8'h02 : 8'ha9);
      rd_chk("res_l", OFF_RES_L, i ? 8'ha5 : 8'h40);
    end
    wr_reg(OFF_CTRL0, 8'hc5);
    conv(10'h001);
    rd_chk("go_cont", OFF_CTRL0, 8'hc5);
    wr_reg(OFF_CTRL3, 8'h08);
    threshold_irq_flag <= 1'b1;
    conv(10'h002);
    rd_chk("go_soi", OFF_CTRL0, 8'hc4);
    threshold_irq_flag <= 1'b0;
    $display("test conversion done");
    wr_reg(OFF_CTRL2, 8'h1a);
    v = 8'hff;
    for (int n = 0; n < 200 && v[3] !== 1'b0; n++) rd_reg(OFF_CTRL2, v);
    chk("clr_cmd", v, 8'h12);
    rd_chk("count", OFF_CNT, 8'h00);
    wr_reg(OFF_RPT, 8'h02);
    wr_reg(OFF_IRQ_EN, 8'h00);
    wr_reg(OFF_CTRL0, 8'h85);
    conv(10'h010);
    wr_reg(OFF_CTRL0, 8'h85);
    conv(10'h012);
    rd_chk("prev", OFF_PREV_L, 8'h10);
    rd_chk("avg_l", OFF_FLT_L, 8'h11);
    rd_chk("avg_h", OFF_FLT_H, 8'h00);
    $display("test average done");
    wr_reg(OFF_CTRL1, 8'he1);
    for (int i = 0; i < 2; i++) begin
      wr_reg(OFF_CTRL0, 8'h85);
      wait_for(1, 1'b1);
      chk("pair_pol", {7'h00, precharge_high}, 8'(1 - i));
      chk("pair_guard", {7'h00, guard_high}, 8'(1 - i));
      conv(i ? 10'h006 : 10'h004);
      rd_chk("pair_stat", OFF_STAT, i ? 8'h00 : 8'h04);
      rd_chk("pair_acc", OFF_ACC_L, i ? 8'h06 : 8'h00);
    end
    wr_reg(OFF_CTRL1, 8'h00);
    wr_reg(OFF_CTRL2, 8'h1c);
    wr_reg(OFF_CTRL0, 8'h85);
    conv(10'h010);
    rd_chk("lpf_acc", OFF_ACC_L, 8'h10);
    rd_chk("lpf_out", OFF_FLT_L, 8'h08);
    $display("test pair and filter done");
    chk("irq_mask", {7'h00, irq}, 8'h00);
    wr_reg(OFF_IRQ_EN, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk("irq_on", {7'h00, irq}, 8'h01);
    wr_reg(OFF_IRQ_CLR, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk("irq_clr", {7'h00, irq}, 8'h00);
    $display("test interrupt done");
    wrap_up;
  end
endmodule
